// *** hdl/csbc_top.sv ***
// chip-select bank: register file, region decode and burst bus sequencer
// assumes an axi4-lite master, a request source on aclk, flash pins outside
`timescale 1ns/1ps
module csbc_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [3:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [3:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transfer requests from the system side
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [31:0] req_addr,
  input wire logic req_write,
  input wire logic req_burst,
  input wire logic [2:0] req_type,
  input wire logic [31:0] req_wdata,
  input wire logic [3:0] req_be,
  // per-beat answers
  output logic rsp_valid,
  output logic rsp_last,
  output logic rsp_err,
  output logic [31:0] rsp_data,
  // flash-side pins
  output logic bank_select_line_n,
  output logic xfer_begin_strobe_n,
  output logic [31:0] mem_addr,
  output logic mem_rd_wr,
  output logic mem_oe_n,
  output logic [3:0] mem_we_be_n,
  output logic burst_continue_out_n,
  input wire logic xfer_done_ack_n,
  // data pins, split three ways
  input wire logic [31:0] dq_i,
  output logic [31:0] dq_o,
  output logic dq_oe
);
  import csbc_pkg::*;

  logic [31:0] base_r, opt_r, burst_unit_config_r;
  logic aw_have_r, w_have_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_fire;
  csbc_state_e state_r;
  logic [3:0] cnt_r;
  logic [2:0] beats_r;
  logic first_r, outside_ack_select_q, late_q, toggle_q, wr_q;
  logic [2:0] beat_wait_count_q;
  logic ack_s1, ack_s2;
  logic [31:0] dq_s1, dq_s2;
  logic beat_d1, beat_d2, last_d1, last_d2;
  logic go, hit, ok, burst_ok, beat_done, more_next;
  logic [2:0] n_beats;
  logic [1:0] low_addr;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  // write address and data taken in either order, answered when both held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CSBC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_have_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r == CSBC_BASE_OFS ||
                        aw_addr_r == CSBC_OPT_OFS ||
                        aw_addr_r == CSBC_BURST_OFS ||
                        aw_addr_r == CSBC_STAT_OFS) ?
                       CSBC_RESP_OKAY : CSBC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;

  // configuration registers; status offset is read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_r <= CSBC_BASE_RST;
      opt_r <= CSBC_OPT_RST;
      burst_unit_config_r <= CSBC_BURST_RST;
    end else if (wr_fire) begin
      if (aw_addr_r == CSBC_BASE_OFS) begin
        base_r <= merge(base_r, w_data_r, w_strb_r) & CSBC_BASE_WMASK;
      end
      if (aw_addr_r == CSBC_OPT_OFS) begin
        opt_r <= merge(opt_r, w_data_r, w_strb_r);
      end
      if (aw_addr_r == CSBC_BURST_OFS) begin
        burst_unit_config_r <= merge(burst_unit_config_r, w_data_r,
                                     w_strb_r) & 32'h0000_0001;
      end
    end
  end

  // read channel: one read in flight, data registered with the answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= CSBC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= CSBC_RESP_OKAY;
      unique case (s_axi_araddr)
        CSBC_BASE_OFS: s_axi_rdata <= base_r;
        CSBC_OPT_OFS: s_axi_rdata <= opt_r;
        CSBC_BURST_OFS: s_axi_rdata <= burst_unit_config_r;
        CSBC_STAT_OFS: s_axi_rdata <= {28'h0000000, beats_r,
                                       state_r != ST_IDLE};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= CSBC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // region, access kind and permission decode of an offered request
  always_comb begin
    hit = base_r[CSBC_ON_BIT] &&
          (((req_addr[31:15] ^ base_r[CSBC_BA_HI:CSBC_BA_LO]) &
            opt_r[CSBC_BA_HI:CSBC_BA_LO] & CSBC_AM_FLOOR) == 17'h00000) &&
          (((req_type ^ base_r[CSBC_AT_HI:CSBC_AT_LO]) &
            opt_r[CSBC_AT_HI:CSBC_AT_LO]) == 3'h0);
    ok = hit && !(req_write && base_r[CSBC_WP_BIT]);
    burst_ok = req_burst && !req_write && !base_r[CSBC_BI_BIT] &&
               burst_unit_config_r[CSBC_BEN_BIT];
    n_beats = burst_ok ? 3'(CSBC_MAX_BEATS - {1'b0, req_addr[3:2]}) :
              3'h1;
    unique case (base_r[CSBC_PS_HI:CSBC_PS_LO])
      CSBC_PS_32: low_addr = 2'h0;
      CSBC_PS_16: low_addr = {req_addr[1], 1'b0};
      default: low_addr = req_addr[1:0];
    endcase
  end

  assign go = req_valid && req_ready;
  // a beat ends on the external ack when that is selected, otherwise when the wait count runs out
  assign beat_done = (state_r == ST_ACC) &&
                     (outside_ack_select_q ? !ack_s2 : (cnt_r == 4'h0));
  assign more_next = beats_r > 3'h2;

  // ack pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_s1 <= 1'b1;
      ack_s2 <= 1'b1;
    end else begin
      ack_s1 <= xfer_done_ack_n;
      ack_s2 <= ack_s1;
    end
  end

  // bus sequencer: select, strobes, wait counting and burst stepping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      req_ready <= 1'b1;
      bank_select_line_n <= 1'b1;
      xfer_begin_strobe_n <= 1'b1;
      mem_addr <= 32'h0000_0000;
      mem_rd_wr <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_we_be_n <= 4'hF;
      burst_continue_out_n <= 1'b1;
      dq_o <= 32'h0000_0000;
      dq_oe <= 1'b0;
      cnt_r <= 4'h0;
      beats_r <= 3'h0;
      first_r <= 1'b0;
      outside_ack_select_q <= 1'b0;
      late_q <= 1'b0;
      toggle_q <= 1'b0;
      wr_q <= 1'b0;
      beat_wait_count_q <= 3'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (go && ok) begin
            state_r <= ST_ACC;
            req_ready <= 1'b0;
            bank_select_line_n <= 1'b0;
            xfer_begin_strobe_n <= 1'b0;
            mem_addr <= {req_addr[31:2], low_addr};
            mem_rd_wr <= !req_write;
            mem_oe_n <= req_write;
            mem_we_be_n <= base_r[CSBC_LANE_BIT] ?
                           (req_write ? 4'h0 : 4'hF) : ~req_be;
            dq_o <= req_wdata;
            dq_oe <= req_write;
            cnt_r <= opt_r[CSBC_SCY_HI:CSBC_SCY_LO];
            beats_r <= n_beats;
            first_r <= 1'b1;
            outside_ack_select_q <= base_r[CSBC_OUTSIDE_ACK_SELECT_BIT];
            late_q <= base_r[CSBC_LATE_BIT];
            toggle_q <= base_r[CSBC_TOGGLE_BIT];
            wr_q <= req_write;
            beat_wait_count_q <= opt_r[CSBC_BEAT_WAIT_COUNT_HI:CSBC_BEAT_WAIT_COUNT_LO];
            burst_continue_out_n <= !((n_beats > 3'h1) &&
              !base_r[CSBC_LATE_BIT] &&
              (!base_r[CSBC_TOGGLE_BIT] || base_r[CSBC_OUTSIDE_ACK_SELECT_BIT] ||
               opt_r[CSBC_SCY_HI:CSBC_SCY_LO] == 4'h0));
          end else if (go) begin
            state_r <= ST_ERR;
            req_ready <= 1'b0;
          end
        end
        ST_ACC: begin
          xfer_begin_strobe_n <= 1'b1;
          if (!beat_done) begin
            if (!outside_ack_select_q) begin
              cnt_r <= cnt_r - 4'h1;
            end
            burst_continue_out_n <= !((beats_r > 3'h1) &&
              !(late_q && first_r) &&
              (!toggle_q || outside_ack_select_q || cnt_r == 4'h1));
          end else if (beats_r == 3'h1) begin
            state_r <= ST_DRAIN;
            bank_select_line_n <= 1'b1;
            mem_oe_n <= 1'b1;
            mem_we_be_n <= 4'hF;
            mem_rd_wr <= 1'b1;
            dq_oe <= 1'b0;
            burst_continue_out_n <= 1'b1;
            beats_r <= 3'h0;
          end else begin
            beats_r <= beats_r - 3'h1;
            mem_addr <= mem_addr + 32'h0000_0004;
            cnt_r <= {1'b0, beat_wait_count_q};
            first_r <= 1'b0;
            burst_continue_out_n <= !(more_next &&
              (!toggle_q || outside_ack_select_q || beat_wait_count_q == 3'h0));
          end
        end
        ST_DRAIN: begin
          if (last_d2) begin
            state_r <= ST_IDLE;
            req_ready <= 1'b1;
          end
        end
        ST_ERR: begin
          state_r <= ST_IDLE;
          req_ready <= 1'b1;
        end
      endcase
    end
  end

  // data pins and beat markers pass two stages so they stay aligned
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dq_s1 <= 32'h0000_0000;
      dq_s2 <= 32'h0000_0000;
      beat_d1 <= 1'b0;
      beat_d2 <= 1'b0;
      last_d1 <= 1'b0;
      last_d2 <= 1'b0;
    end else begin
      dq_s1 <= dq_i;
      dq_s2 <= dq_s1;
      beat_d1 <= beat_done;
      beat_d2 <= beat_d1;
      last_d1 <= beat_done && beats_r == 3'h1;
      last_d2 <= last_d1;
    end
  end

  // answers: one pulse per beat, or one error pulse for a refused request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_valid <= 1'b0;
      rsp_last <= 1'b0;
      rsp_err <= 1'b0;
      rsp_data <= 32'h0000_0000;
    end else begin
      rsp_valid <= beat_d2 || state_r == ST_ERR;
      rsp_last <= last_d2 || state_r == ST_ERR;
      rsp_err <= state_r == ST_ERR;
      rsp_data <= (beat_d2 && !wr_q) ? dq_s2 : 32'h0000_0000;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  miss_no_select_a: assert property (go && !hit |=> bank_select_line_n)
    else $error("select asserted on a decode miss");
  write_protect_a: assert property (go && req_write &&
    base_r[CSBC_WP_BIT] |=> bank_select_line_n && rsp_err == 1'b0 ##1
    rsp_err) else $error("write reached protected bank");
  start_strobe_a: assert property ($fell(xfer_begin_strobe_n) |->
    !bank_select_line_n ##1 xfer_begin_strobe_n)
    else $error("begin strobe not one cycle with select");
  first_beat_a: assert property (go && ok && !base_r[CSBC_OUTSIDE_ACK_SELECT_BIT] &&
    opt_r[CSBC_SCY_HI:CSBC_SCY_LO] == 4'h2 |=> !beat_done ##1 !beat_done
    ##1 beat_done) else $error("first beat length wrong");
  burst_off_a: assert property (go && ok && (base_r[CSBC_BI_BIT] ||
    !burst_unit_config_r[CSBC_BEN_BIT]) |=> beats_r == 3'h1)
    else $error("burst ran while inhibited");
  aligned_four_a: assert property (go && ok && req_addr[3:0] != 4'h0
    |=> beats_r < 3'h4) else $error("four beats from unaligned");
  step_four_a: assert property (beat_done && beats_r > 3'h1 |=>
    mem_addr == $past(mem_addr) + 32'h0000_0004)
    else $error("burst address step wrong");
  low_lines_a: assert property (!bank_select_line_n &&
    base_r[CSBC_PS_HI:CSBC_PS_LO] == CSBC_PS_32 |->
    mem_addr[1:0] == 2'h0) else $error("low lines used on 32-bit");
  ext_ack_a: assert property (state_r == ST_ACC && outside_ack_select_q && !beat_done
    |=> cnt_r == $past(cnt_r))
    else $error("wait count ran under external ack");
  late_beat_a: assert property (state_r == ST_ACC && first_r && late_q
    |-> burst_continue_out_n) else $error("burst continue too early");
  lane_we_a: assert property (!bank_select_line_n && mem_rd_wr &&
    base_r[CSBC_LANE_BIT] |-> mem_we_be_n == 4'hF)
    else $error("write enable on a read");
  reserved_zero_a: assert property (base_r[9] == 1'b0 &&
    base_r[7:6] == 2'h0) else $error("reserved bits set");

  four_beat_c: cover property (go && ok && n_beats == 3'h4);
  write_c: cover property (go && ok && req_write);
  refused_c: cover property (go && !ok);
  ext_ack_c: cover property (beat_done && outside_ack_select_q);
endmodule

// *** hdl/csbc_pkg.sv ***
// constants for the chip-select bank configuration and decode block
// assumes an axi4-lite register bus, 32-bit data, one bank per instance
package csbc_pkg;
  // register byte offsets
  localparam logic [3:0] CSBC_BASE_OFS = 4'h0;
  localparam logic [3:0] CSBC_OPT_OFS = 4'h4;
  localparam logic [3:0] CSBC_BURST_OFS = 4'h8;
  localparam logic [3:0] CSBC_STAT_OFS = 4'hC;
  // reset values
  localparam logic [31:0] CSBC_BASE_RST = 32'h0000_0000;
  localparam logic [31:0] CSBC_OPT_RST = 32'h0000_00F0;
  localparam logic [31:0] CSBC_BURST_RST = 32'h0000_0000;
  // writable bits of the base register, reserved ones held at zero
  localparam logic [31:0] CSBC_BASE_WMASK = 32'hFFFF_FD3F;
  // base register fields (msb-first bit n sits at bit 31-n)
  localparam int CSBC_BA_HI = 31;
  localparam int CSBC_BA_LO = 15;
  localparam int CSBC_AT_HI = 14;
  localparam int CSBC_AT_LO = 12;
  localparam int CSBC_PS_HI = 11;
  localparam int CSBC_PS_LO = 10;
  localparam int CSBC_WP_BIT = 8;
  localparam int CSBC_LANE_BIT = 5;
  localparam int CSBC_TOGGLE_BIT = 4;
  localparam int CSBC_LATE_BIT = 3;
  localparam int CSBC_OUTSIDE_ACK_SELECT_BIT = 2;
  localparam int CSBC_BI_BIT = 1;
  localparam int CSBC_ON_BIT = 0;
  // option register fields
  localparam int CSBC_SCY_HI = 7;
  localparam int CSBC_SCY_LO = 4;
  localparam int CSBC_BEAT_WAIT_COUNT_HI = 3;
  localparam int CSBC_BEAT_WAIT_COUNT_LO = 1;
  // global burst configuration field
  localparam int CSBC_BEN_BIT = 0;
  // lowest compared address bit never matters: 64 kbyte least region
  localparam logic [16:0] CSBC_AM_FLOOR = 17'h1FFFE;
  // port width codes
  localparam logic [1:0] CSBC_PS_32 = 2'h0;
  localparam logic [1:0] CSBC_PS_16 = 2'h2;
  localparam logic [2:0] CSBC_MAX_BEATS = 3'h4;
  localparam logic [1:0] CSBC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CSBC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_ACC, ST_DRAIN, ST_ERR} csbc_state_e;
endpackage

// *** verif/csbc_flash_model.sv ***
// flash-side partner: answers reads from the address pins, optional ack
// assumes the bank pins of csbc_top and the same single clock
`timescale 1ns/1ps
module csbc_flash_model (
  // clock
  input wire logic aclk,
  // controller pins
  input wire logic sel_n,
  input wire logic oe_n,
  input wire logic [31:0] addr,
  // bench knob: 0 never acks, else ack after that many selected cycles
  input wire logic [3:0] ack_dly,
  // flash answers
  output logic [31:0] dq,
  output logic ack_n
);
  logic [31:0] last_q = 32'h0000_0000;
  logic [3:0] cnt = 4'h0;
  logic drv;
  // word made from the address; the burst step input is ignored
  assign drv = !sel_n && !oe_n;
  always_comb dq = drv ? (addr ^ 32'hA5A5_A5A5) : ~last_q;
  // a released bus shows the inverse of the last word, never a stale copy
  always_ff @(posedge aclk) begin
    if (drv)
      last_q <= dq;
  end
  // selected-cycle count, saturating
  always_ff @(posedge aclk) begin
    if (sel_n)
      cnt <= 4'h0;
    else if (cnt != 4'hF)
      cnt <= cnt + 4'h1;
  end
  // ack low once the selected-cycle count reaches a nonzero ack_dly; pull-up when released
  assign ack_n = !(ack_dly != 4'h0 && !sel_n && cnt >= ack_dly);
endmodule

// *** verif/tb.sv ***
// bench for the chip-select bank block: register and request traffic
// assumes csbc_top with the flash model on its pins, one 20 MHz clock
`timescale 1ns/1ps
module tb;
  import csbc_pkg::*;
  localparam logic [31:0] A = 32'h1234_0000;
  localparam logic [31:0] K = 32'hA5A5_A5A5;
  localparam logic [31:0] OPT2 = 32'hFFFF_8020;
  // bench state
  int n_errors = 0;
  int check_count = 0;
  int nb, lat, cyc, lat_a, low_a, lowc;
  logic er, dok, tk, psel, st0, c0;
  logic [31:0] a0;
  logic [3:0] wen;
  // design wiring
  logic aclk, aresetn, awv, wv, bre, arv, rre, awr, wrdy, bv, arr, rv;
  logic [3:0] awa, ara, stb, ack_dly, qbe, we_n;
  logic [2:0] prt, qt;
  logic [1:0] brs, rrs;
  logic [31:0] wd, rdt, qa, qd, rsd, maddr, dq_i, dq_o;
  logic qv, qr, qw, qb, rsv, rsl, rse, sel_n, stb_n, rdwr, oe_n, cont_n;
  logic ack_n, dq_oe;

  csbc_top u_csbc_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awprot(prt), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(stb), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(brs), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arprot(prt),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .req_valid(qv), .req_ready(qr), .req_addr(qa), .req_write(qw),
    .req_burst(qb), .req_type(qt), .req_wdata(qd), .req_be(qbe),
    .rsp_valid(rsv), .rsp_last(rsl), .rsp_err(rse), .rsp_data(rsd),
    .bank_select_line_n(sel_n), .xfer_begin_strobe_n(stb_n),
    .mem_addr(maddr), .mem_rd_wr(rdwr), .mem_oe_n(oe_n),
    .mem_we_be_n(we_n), .burst_continue_out_n(cont_n),
    .xfer_done_ack_n(ack_n), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));

  csbc_flash_model u_csbc_flash_model (
    .aclk(aclk), .sel_n(sel_n), .oe_n(oe_n), .addr(maddr),
    .ack_dly(ack_dly), .dq(dq_i), .ack_n(ack_n));

  // clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // pin watcher: first selected cycle and per-transfer summaries
  always @(posedge aclk) begin
    psel <= sel_n;
    if (!sel_n) begin
      wen <= wen & we_n;
      if (!cont_n)
        lowc <= lowc + 1;
      if (psel) begin
        st0 <= stb_n;
        a0 <= maddr;
        c0 <= cont_n;
      end
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic tmo;
    n_errors++;
    give_verdict();
  endtask

  // one register write, expected response code
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] ep);
    awa <= a;
    wd <= d;
    stb <= 4'hF;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (bv === 1'b1 && !awv && !wv) begin
        bre <= 1'b0;
        check({30'h0, brs}, {30'h0, ep});
        return;
      end
      if (awv && awr === 1'b1)
        awv <= 1'b0;
      if (wv && wrdy === 1'b1)
        wv <= 1'b0;
    end
    tmo();
  endtask

  // one register read, expected data and response code
  task automatic rd(input logic [3:0] a, input logic [31:0] ed,
                    input logic [1:0] ep);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (rv === 1'b1 && !arv) begin
        rre <= 1'b0;
        check(rdt, ed);
        check({30'h0, rrs}, {30'h0, ep});
        return;
      end
      if (arv && arr === 1'b1)
        arv <= 1'b0;
    end
    tmo();
  endtask

  task automatic cfg(input logic [31:0] b, input logic [31:0] o);
    wr(CSBC_BASE_OFS, b, CSBC_RESP_OKAY);
    wr(CSBC_OPT_OFS, o, CSBC_RESP_OKAY);
  endtask

  // offer one request, gather its answers, compare beats and refusal
  task automatic go(input logic [31:0] a, input logic w, input logic b,
                    input logic [2:0] t, input int enb, input logic eer);
    qa <= a;
    qw <= w;
    qb <= b;
    qt <= t;
    qd <= ~a;
    qv <= 1'b1;
    nb = 0;
    er = 1'b0;
    dok = 1'b1;
    tk = 1'b0;
    cyc = 0;
    lowc = 0;
    wen = 4'hF;
    for (int i = 0; i < 80; i++) begin
      @(posedge aclk);
      cyc++;
      if (!tk && qr === 1'b1) begin
        qv <= 1'b0;
        tk = 1'b1;
        cyc = 0;
      end
      if (tk && rsv === 1'b1) begin
        if (nb == 0)
          lat = cyc;
        if (rsd !== (({a[31:2], 2'b00} + 32'(nb * 4)) ^ K))
          dok = 1'b0;
        nb++;
        if (rse === 1'b1)
          er = 1'b1;
        if (rsl === 1'b1) begin
          check(32'(nb), 32'(enb));
          check({31'h0, er}, {31'h0, eer});
          return;
        end
      end
    end
    tmo();
  endtask

  initial begin
    {awv, wv, bre, arv, rre, qv, qw, qb} = 8'h00;
    {awa, ara, stb, ack_dly} = 16'h0000;
    {prt, qt} = 6'h00;
    {wd, qa, qd} = 96'h0;
    qbe = 4'h5;
    psel = 1'b1;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CSBC_BASE_OFS, CSBC_BASE_RST, CSBC_RESP_OKAY);
    rd(CSBC_OPT_OFS, CSBC_OPT_RST, CSBC_RESP_OKAY);
    rd(CSBC_BURST_OFS, CSBC_BURST_RST, CSBC_RESP_OKAY);
    rd(4'h6, 32'h0, CSBC_RESP_SLVERR);
    wr(4'hA, 32'h1, CSBC_RESP_SLVERR);
    wr(CSBC_BASE_OFS, 32'hFFFF_FFFF, CSBC_RESP_OKAY);
    rd(CSBC_BASE_OFS, CSBC_BASE_WMASK, CSBC_RESP_OKAY);
    cfg(A, OPT2);
    go(A, 1'b0, 1'b0, 3'h0, 1, 1'b1);
    wr(CSBC_BURST_OFS, 32'h1, CSBC_RESP_OKAY);
    cfg(A | 32'h1, OPT2);
    // every start offset inside an aligned group of four words
    for (int k = 0; k < 4; k++) begin
      go(A + 32'(4 * k), 1'b0, 1'b1, 3'h0, 4 - k, 1'b0);
      check({31'h0, dok}, 32'h1);
      check(32'(cyc - lat), 32'(3 - k));
    end
    go(A, 1'b0, 1'b1, 3'h0, 4, 1'b0);
    lat_a = lat;
    low_a = lowc;
    check({31'h0, st0}, 32'h0);
    check(a0, A);
    check({31'h0, c0}, 32'h0);
    go(A + 32'h0000_8000, 1'b0, 1'b0, 3'h0, 1, 1'b0);
    go(A + 32'h0001_0000, 1'b0, 1'b0, 3'h0, 1, 1'b1);
    cfg(A | 32'h1, 32'h7FFF_8020);
    go(A ^ 32'h8000_0000, 1'b0, 1'b0, 3'h0, 1, 1'b0);
    cfg(A | 32'h5001, 32'hFFFF_F020);
    go(A, 1'b0, 1'b0, 3'h5, 1, 1'b0);
    go(A, 1'b0, 1'b0, 3'h1, 1, 1'b1);
    cfg(A | 32'h5001, OPT2);
    go(A, 1'b0, 1'b0, 3'h1, 1, 1'b0);
    cfg(A | 32'h1, 32'hFFFF_8040);
    go(A, 1'b0, 1'b1, 3'h0, 4, 1'b0);
    check(32'(lat - lat_a), 32'h2);
    cfg(A | 32'h3, OPT2);
    go(A, 1'b0, 1'b1, 3'h0, 1, 1'b0);
    cfg(A | 32'h9, OPT2);
    go(A, 1'b0, 1'b1, 3'h0, 4, 1'b0);
    check({31'h0, c0}, 32'h1);
    cfg(A | 32'h11, OPT2);
    go(A, 1'b0, 1'b1, 3'h0, 4, 1'b0);
    check(32'(lowc < low_a), 32'h1);
    cfg(A | 32'h21, OPT2);
    go(A, 1'b1, 1'b0, 3'h0, 1, 1'b0);
    check({28'h0, wen}, 32'h0);
    cfg(A | 32'h1, OPT2);
    go(A, 1'b1, 1'b0, 3'h0, 1, 1'b0);
    check({28'h0, wen}, 32'hA);
    cfg(A | 32'h101, OPT2);
    go(A, 1'b1, 1'b0, 3'h0, 1, 1'b1);
    go(A, 1'b0, 1'b0, 3'h0, 1, 1'b0);
    cfg(A | 32'h801, OPT2);
    go(A + 32'h2, 1'b0, 1'b0, 3'h0, 1, 1'b0);
    check(a0, A + 32'h2);
    cfg(A | 32'h1, OPT2);
    go(A + 32'h2, 1'b0, 1'b0, 3'h0, 1, 1'b0);
    check(a0, A);
    wr(CSBC_BURST_OFS, 32'h0, CSBC_RESP_OKAY);
    go(A, 1'b0, 1'b1, 3'h0, 1, 1'b0);
    // external ack with a long internal count: only the ack sets timing
    cfg(A | 32'h5, 32'hFFFF_80F0);
    ack_dly <= 4'h3;
    go(A, 1'b0, 1'b0, 3'h0, 1, 1'b0);
    lat_a = lat;
    ack_dly <= 4'h7;
    go(A, 1'b0, 1'b0, 3'h0, 1, 1'b0);
    check(32'(lat - lat_a), 32'h4);
    give_verdict();
  end
endmodule
